// ===== logic/vic_pkg.sv
// Constants, types and register map of the vectored interrupt controller.
// Assumes one system clock, a core on the same clock and AXI4-Lite software access.
package vic_pkg;
  localparam int NUM_SRC = 118;
  localparam int NUM_TRAP = 8;
  localparam int PRIO_W = 3;
  localparam int VEC_W = 7;
  localparam int LVL_W = 4;
  localparam int PADDR_W = 24;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 4;
  localparam int FLAG_WORDS = 4;
  localparam int PRIO_WORDS = 15;
  localparam int PRIO_PER_WORD = 8;
  localparam logic [PADDR_W-1:0] IVT_BASE = 24'h000004;
  localparam logic [PADDR_W-1:0] ALT_OFFSET = 24'h000100;
  localparam logic [PADDR_W-1:0] RESET_PC = 24'h000000;
  localparam logic [VEC_W-1:0] IRQ_VEC_OFS = 7'h08;
  localparam logic [LVL_W-1:0] TRAP_LVL = 4'h8;
  localparam logic [NUM_TRAP-1:0] TRAP_IMPL = 8'h3E;
  localparam logic [NUM_SRC-1:0] SRC_IMPL = {46'h0, 8'hF7, 64'hBFFF_DFFF_FFFB_7FFF};
  localparam logic [ADDR_W-1:0] OFS_CTRL2 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WINNER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TRAP = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAG0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EN0 = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PRIO0 = 8'h40;
  localparam int ALT_BIT = 15;
  localparam logic [CNT_W-1:0] PM_LAT = 4'h2;
  localparam logic [CNT_W-1:0] ENTRY_CYCLES = 4'h5;
  localparam logic [CNT_W-1:0] RET_CYCLES = 4'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic req;
    logic [VEC_W-1:0] vec;
    logic [LVL_W-1:0] lvl;
  } vic_irq_t;

  typedef struct packed {
    logic valid;
    logic [PADDR_W-1:0] addr;
  } vic_isr_t;

  typedef enum {ST_IDLE, ST_FETCH, ST_RET} vic_state_t;
endpackage

// ===== logic/vic_top.sv
// Vectored interrupt controller with AXI4-Lite register access.
// Assumes source requests arrive from pins or other logic and are synchronised here;
// the core, its level, trap lines and program memory share aclk.
`timescale 1ns/1ps
`default_nettype none
module vic_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [vic_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [vic_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [vic_pkg::NUM_SRC-1:0] src_req,
  input wire logic [vic_pkg::NUM_TRAP-1:0] trap_req,
  input wire logic [vic_pkg::LVL_W-1:0] core_ipl,
  input wire logic core_take,
  input wire logic core_ret,
  output vic_pkg::vic_irq_t irq_out,
  output logic pm_rd_req,
  output logic [vic_pkg::PADDR_W-1:0] pm_rd_addr,
  input wire logic [vic_pkg::PADDR_W-1:0] pm_rd_data,
  output vic_pkg::vic_isr_t isr_out,
  output logic ret_done
);
  import vic_pkg::*;

  function automatic logic reg_known(input logic [5:0] idx);
    logic [5:0] f;
    logic [5:0] e;
    logic [5:0] p;
    f = OFS_FLAG0[7:2];
    e = OFS_EN0[7:2];
    p = OFS_PRIO0[7:2];
    reg_known = (idx == OFS_CTRL2[7:2]) || (idx == OFS_WINNER[7:2]) ||
      (idx == OFS_TRAP[7:2]) || (idx >= f && idx < f + 6'(FLAG_WORDS)) ||
      (idx >= e && idx < e + 6'(FLAG_WORDS)) ||
      (idx >= p && idx < p + 6'(PRIO_WORDS));
  endfunction

  // Register bus state
  logic aw_full_r;
  logic w_full_r;
  logic [5:0] aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Controller state
  logic alt_r;
  logic [NUM_SRC-1:0] flag_r;
  logic [NUM_SRC-1:0] en_r;
  logic [NUM_SRC-1:0][PRIO_W-1:0] prio_r;
  logic [NUM_TRAP-1:0] trap_r;
  logic [NUM_SRC-1:0] sync1_r;
  logic [NUM_SRC-1:0] sync2_r;
  vic_irq_t irq_r;
  vic_state_t st_r;
  logic [CNT_W-1:0] cnt_r;
  logic [VEC_W-1:0] vec_l_r;
  logic [LVL_W-1:0] lvl_l_r;
  logic alt_l_r;
  logic pm_req_r;
  logic [PADDR_W-1:0] pm_addr_r;
  logic [PADDR_W-1:0] pm_data_r;
  vic_isr_t isr_r;
  logic ret_done_r;

  // Write decode
  wire do_wr = aw_full_r && w_full_r && !bvalid_r;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] wbits = wdata_r & wmask;
  wire wr_ctrl2 = do_wr && aw_idx_r == OFS_CTRL2[7:2];
  wire wr_trap = do_wr && aw_idx_r == OFS_TRAP[7:2];
  wire wr_hit = reg_known(aw_idx_r);
  wire ar_take = s_axi_arvalid && !rvalid_r;
  wire [5:0] ar_idx = s_axi_araddr[7:2];

  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready = !w_full_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  assign irq_out = irq_r;
  assign pm_rd_req = pm_req_r;
  assign pm_rd_addr = pm_addr_r;
  assign isr_out = isr_r;
  assign ret_done = ret_done_r;

  // Pending sources: flag, enable and an implemented slot
  wire [NUM_SRC-1:0] pend = flag_r & en_r & SRC_IMPL;
  wire [NUM_TRAP-1:0] trap_pend = trap_r & TRAP_IMPL;

  // Per-source flag, enable and priority storage
  logic [FLAG_WORDS*32-1:0] flag_flat;
  logic [FLAG_WORDS*32-1:0] en_flat;
  logic [PRIO_WORDS*32-1:0] prio_flat;
  assign flag_flat[FLAG_WORDS*32-1:NUM_SRC] = '0;
  assign en_flat[FLAG_WORDS*32-1:NUM_SRC] = '0;

  for (genvar i = 0; i < PRIO_WORDS * PRIO_PER_WORD; i++) begin : g_src
    if (i < NUM_SRC) begin : g_live
      localparam int FW = i / 32;
      localparam int FB = i % 32;
      localparam int PB = 4 * (i % PRIO_PER_WORD);
      wire hit_f = do_wr && aw_idx_r == OFS_FLAG0[7:2] + 6'(FW);
      wire hit_e = do_wr && aw_idx_r == OFS_EN0[7:2] + 6'(FW);
      wire hit_p = do_wr && aw_idx_r == OFS_PRIO0[7:2] + 6'(i / PRIO_PER_WORD);
      wire set_f = sync2_r[i] && SRC_IMPL[i];
      wire clr_f = hit_f && wbits[FB];
      assign flag_flat[i] = flag_r[i];
      assign en_flat[i] = en_r[i];
      assign prio_flat[4 * i +: 4] = {1'b0, prio_r[i]};
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          flag_r[i] <= 1'b0;
          en_r[i] <= 1'b0;
          prio_r[i] <= '0;
        end else begin
          flag_r[i] <= set_f || (flag_r[i] && !clr_f);
          if (hit_e && wmask[FB]) begin
            en_r[i] <= wdata_r[FB];
          end
          if (hit_p && wmask[PB]) begin
            prio_r[i] <= wdata_r[PB +: PRIO_W];
          end
        end
      end
    end else begin : g_pad
      assign prio_flat[4 * i +: 4] = 4'h0;
    end
  end

  // Source synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= src_req;
      sync2_r <= sync1_r;
    end
  end

  // Highest level wins; strict compare in ascending order keeps the lowest number
  logic [PRIO_W-1:0] best_lvl;
  logic [VEC_W-1:0] best_idx;
  always_comb begin
    best_lvl = '0;
    best_idx = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (pend[i] && prio_r[i] > best_lvl) begin
        best_lvl = prio_r[i];
        best_idx = VEC_W'(i);
      end
    end
  end

  // Lowest pending trap wins
  logic trap_any;
  logic [VEC_W-1:0] trap_idx;
  always_comb begin
    trap_any = 1'b0;
    trap_idx = '0;
    for (int t = NUM_TRAP - 1; t >= 0; t--) begin
      if (trap_pend[t]) begin
        trap_any = 1'b1;
        trap_idx = VEC_W'(t);
      end
    end
  end

  // Traps occupy vectors 0..7, request n sits at vector n+8
  wire [VEC_W-1:0] win_vec = trap_any ? trap_idx : best_idx + IRQ_VEC_OFS;
  wire [LVL_W-1:0] win_lvl = trap_any ? TRAP_LVL : {1'b0, best_lvl};
  wire win_req = win_lvl > core_ipl;

  // Vector word address: base + 2 * vector, alternate table 0x100 higher
  wire [PADDR_W-1:0] vec_ofs = {16'h0, irq_r.vec, 1'b0};
  wire [PADDR_W-1:0] tbl_base = alt_r ? IVT_BASE + ALT_OFFSET : IVT_BASE;
  wire take_ok = st_r == ST_IDLE && core_take && irq_r.req;

  // Single merged request towards the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= '0;
    end else begin
      irq_r <= '{req: win_req, vec: win_vec, lvl: win_lvl};
    end
  end

  // Entry and return sequencer with fixed cycle counts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      cnt_r <= '0;
      vec_l_r <= '0;
      lvl_l_r <= '0;
      alt_l_r <= 1'b0;
      pm_req_r <= 1'b0;
      pm_addr_r <= RESET_PC;
      pm_data_r <= RESET_PC;
      isr_r <= '0;
      ret_done_r <= 1'b0;
    end else begin
      pm_req_r <= 1'b0;
      isr_r.valid <= 1'b0;
      ret_done_r <= 1'b0;
      cnt_r <= cnt_r + 4'h1;
      case (st_r)
        ST_IDLE: begin
          cnt_r <= '0;
          if (take_ok) begin
            vec_l_r <= irq_r.vec;
            lvl_l_r <= irq_r.lvl;
            alt_l_r <= alt_r;
            pm_addr_r <= tbl_base + vec_ofs;
            pm_req_r <= 1'b1;
            st_r <= ST_FETCH;
          end else if (core_ret) begin
            st_r <= ST_RET;
          end
        end
        ST_FETCH: begin
          if (cnt_r == PM_LAT) begin
            pm_data_r <= pm_rd_data;
          end
          if (cnt_r == ENTRY_CYCLES - 4'h1) begin
            isr_r <= '{valid: 1'b1, addr: pm_data_r};
            st_r <= ST_IDLE;
          end
        end
        ST_RET: begin
          if (cnt_r == RET_CYCLES - 4'h1) begin
            ret_done_r <= 1'b1;
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Control and trap registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alt_r <= 1'b0;
      trap_r <= '0;
    end else begin
      if (wr_ctrl2 && wmask[ALT_BIT]) begin
        alt_r <= wdata_r[ALT_BIT];
      end
      trap_r <= trap_req | (trap_r & ~(wr_trap ? wbits[NUM_TRAP-1:0] : '0));
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_idx_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_r) begin
        aw_full_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[7:2];
      end
      if (s_axi_wvalid && !w_full_r) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read data selection
  logic [31:0] rd_mux;
  logic [5:0] rel_f;
  logic [5:0] rel_e;
  logic [5:0] rel_p;
  assign rel_f = ar_idx - OFS_FLAG0[7:2];
  assign rel_e = ar_idx - OFS_EN0[7:2];
  assign rel_p = ar_idx - OFS_PRIO0[7:2];
  always_comb begin
    rd_mux = 32'h0;
    if (ar_idx == OFS_CTRL2[7:2]) begin
      rd_mux[ALT_BIT] = alt_r;
    end else if (ar_idx == OFS_WINNER[7:2]) begin
      rd_mux = {13'h0, st_r != ST_IDLE, alt_l_r, irq_r.req, 4'h0, lvl_l_r, 1'b0, vec_l_r};
    end else if (ar_idx == OFS_TRAP[7:2]) begin
      rd_mux[NUM_TRAP-1:0] = trap_r;
    end else if (rel_f < 6'(FLAG_WORDS)) begin
      rd_mux = flag_flat[32 * rel_f[1:0] +: 32];
    end else if (rel_e < 6'(FLAG_WORDS)) begin
      rd_mux = en_flat[32 * rel_e[1:0] +: 32];
    end else if (rel_p < 6'(PRIO_WORDS)) begin
      rd_mux = prio_flat[32 * rel_p[3:0] +: 32];
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= reg_known(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/vic_top_properties.sv
// Checker for the core-facing ports of the interrupt controller.
// Assumes it is bound to vic_top and shares its clock and reset.
`timescale 1ns/1ps
`default_nettype none
module vic_top_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [vic_pkg::LVL_W-1:0] core_ipl,
  input wire logic core_take,
  input wire logic core_ret,
  input wire vic_pkg::vic_irq_t irq_out,
  input wire logic pm_rd_req,
  input wire logic [vic_pkg::PADDR_W-1:0] pm_rd_addr,
  input wire logic [vic_pkg::PADDR_W-1:0] pm_rd_data,
  input wire vic_pkg::vic_isr_t isr_out,
  input wire logic ret_done
);
  import vic_pkg::*;
  logic busy_r, busy_nxt, idle, acc_take, acc_ret;
  assign idle = !busy_r || isr_out.valid || ret_done;
  assign acc_take = core_take && irq_out.req && idle;
  assign acc_ret = core_ret && idle && !acc_take;
  assign busy_nxt = (acc_take || acc_ret) ? 1'b1 : (idle ? 1'b0 : busy_r);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_FETCH_ADDR: assert property (acc_take |=> pm_rd_req &&
    pm_rd_addr[7:0] == 8'(2 * $past(irq_out.vec) + 4) && pm_rd_addr[23:9] == 15'h0000)
    else $error("vector fetch address wrong");
  AST_ENTRY_TIME: assert property (acc_take |=> !isr_out.valid [*5] ##1 isr_out.valid)
    else $error("entry latency wrong");
  AST_ISR_ADDR: assert property (isr_out.valid |-> isr_out.addr == $past(pm_rd_data, 3))
    else $error("service address not fetched entry");
  AST_RET_TIME: assert property (acc_ret |=> !ret_done [*3] ##1 ret_done)
    else $error("return latency wrong");
  AST_REQ_IPL: assert property (irq_out.req == (irq_out.lvl > $past(core_ipl)))
    else $error("request not tied to core level");
  AST_TRAP_LVL: assert property (irq_out.req && irq_out.vec < 7'h08 |-> irq_out.lvl == TRAP_LVL)
    else $error("trap level wrong");
  AST_USER_LVL: assert property (irq_out.req && irq_out.vec > 7'h07 |-> irq_out.lvl inside {[1:7]})
    else $error("user level out of range");
  AST_NO_RESERVED: assert property (irq_out.req |->
    !(irq_out.vec inside {0, 6, 7, 23, 26, 53, 70, 75, [80:125]}))
    else $error("reserved vector requested");
  AST_PM_PULSE: assert property (pm_rd_req |=> !pm_rd_req)
    else $error("fetch strobe longer than one cycle");
  cover property (acc_take && irq_out.vec < 7'h08);
  cover property (acc_ret);
  cover property (isr_out.valid && pm_rd_addr[8]);
endmodule
bind vic_top vic_top_properties u_props (.aclk(aclk), .aresetn(aresetn), .core_ipl(core_ipl),
  .core_take(core_take), .core_ret(core_ret), .irq_out(irq_out), .pm_rd_req(pm_rd_req),
  .pm_rd_addr(pm_rd_addr), .pm_rd_data(pm_rd_data), .isr_out(isr_out), .ret_done(ret_done));
`default_nettype wire

// ===== tb/vic_core_model.sv
// Program memory of the core, answering vector fetches.
// Assumes one fetch at a time; data shows only in its one valid cycle.
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
  input wire logic aclk,
  input wire logic [vic_pkg::PADDR_W-1:0] pm_rd_addr,
  input wire logic pm_rd_req,
  output logic [vic_pkg::PADDR_W-1:0] pm_rd_data
);
  import vic_pkg::*;
  logic [PADDR_W-1:0] addr_r = 24'h000000;
  logic [PADDR_W-1:0] word;
  logic [1:0] cnt_r = 2'h0;
  assign word = addr_r ^ 24'h3C0000;
  assign pm_rd_data = (cnt_r == 2'h1) ? word : ~word;
  always_ff @(posedge aclk) begin
    if (pm_rd_req) begin
      addr_r <= pm_rd_addr;
      cnt_r <= 2'h2;
    end else if (cnt_r != 2'h0) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule
`default_nettype wire

// ===== tb/vic_top_test.sv
// Self-checking bench for the interrupt controller.
// Assumes the memory model and the bound checker sit beside the design.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module vic_top_test;
  import vic_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awv = 1'b0, wv = 1'b0, arv = 1'b0, take = 1'b0, ret = 1'b0;
  logic awr, wr, bv, arr, rv, pmq, rdone, ta, tw;
  logic [ADDR_W-1:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, d;
  logic [1:0] br, rr, resp;
  logic [NUM_SRC-1:0] src = '0;
  logic [NUM_TRAP-1:0] trap = 8'h00;
  logic [LVL_W-1:0] ipl = 4'h0;
  logic [PADDR_W-1:0] pma, pmd;
  vic_irq_t irq;
  vic_isr_t isr;
  int mismatches = 0, checks_done = 0, s, n;
  int r[11][5] = '{'{0, 1, 1, 0, 8}, '{5, 7, 1, 6, 13}, '{5, 7, 1, 7, 0}, '{44, 3, 1, 0, 52},
    '{71, 2, 1, 0, 79}, '{15, 4, 1, 0, 0}, '{18, 4, 1, 0, 0}, '{45, 4, 1, 0, 0},
    '{20, 0, 1, 0, 0}, '{20, 5, 0, 0, 0}, '{72, 5, 1, 0, 0}};
  vic_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .src_req(src), .trap_req(trap),
    .core_ipl(ipl), .core_take(take), .core_ret(ret), .irq_out(irq), .pm_rd_req(pmq),
    .pm_rd_addr(pma), .pm_rd_data(pmd), .isr_out(isr), .ret_done(rdone));
  vic_core_model pm (.aclk(aclk), .pm_rd_addr(pma), .pm_rd_req(pmq), .pm_rd_data(pmd));
  initial begin
    forever #25 aclk = ~aclk;
  end
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task wt(input int k);
    repeat (k) @(negedge aclk);
  endtask
  task axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    forever begin
      @(negedge aclk);
      if (!awv && !wv) break;
      ta = awv && awr;
      tw = wv && wr;
      @(posedge aclk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end
    forever begin
      ta = bv;
      resp = br;
      @(posedge aclk);
      if (ta) break;
      @(negedge aclk);
    end
  endtask
  task axr(input logic [7:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = arv && arr;
      tw = rv;
      d = rd;
      resp = rr;
      @(posedge aclk);
      if (ta) arv <= 1'b0;
      if (tw) break;
    end
  endtask
  task take_chk(input logic [23:0] a);
    @(posedge aclk);
    take <= 1'b1;
    @(posedge aclk);
    take <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      @(negedge aclk);
    end while (!isr.valid && n < 12);
    `CHK("entry", ENTRY_CYCLES, n)
    `CHK("pm_addr", a, pma)
    `CHK("isr", a ^ 24'h3C0000, isr.addr)
  endtask
  initial begin
    wt(4);
    `CHK("rst_irq", 12'h000, irq)
    `CHK("rst_pc", RESET_PC, pma)
    @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFS_CTRL2);
    `CHK("ctrl", 32'h0, d)
    axr(8'hFC);
    `CHK("rresp", RESP_SLVERR, resp)
    axw(8'hFC, 32'h1);
    `CHK("bresp", RESP_SLVERR, resp)
    for (int i = 0; i < 11; i++) begin
      s = r[i][0];
      axw(OFS_EN0 + 8'(4 * (s / 32)), 32'(r[i][2]) << (s % 32));
      axw(OFS_PRIO0 + 8'(4 * (s / 8)), 32'(r[i][1]) << (4 * (s % 8)));
      ipl <= 4'(r[i][3]);
      src[s] <= 1'b1;
      wt(6);
      `CHK("req", r[i][4] != 0, irq.req)
      if (r[i][4] != 0) `CHK("vec", 7'(r[i][4]), irq.vec)
      if (r[i][4] != 0) `CHK("lvl", 4'(r[i][1]), irq.lvl)
      @(posedge aclk);
      src[s] <= 1'b0;
      wt(4);
      axw(OFS_FLAG0 + 8'(4 * (s / 32)), 32'h1 << (s % 32));
      axw(OFS_EN0 + 8'(4 * (s / 32)), 32'h0);
    end
    axw(OFS_EN0, 32'hA);
    axw(OFS_PRIO0, 32'h5050);
    axw(OFS_EN0 + 8'h04, 32'h100);
    axw(OFS_PRIO0 + 8'h14, 32'h6);
    src[1] <= 1'b1;
    src[3] <= 1'b1;
    wt(6);
    `CHK("tie", 7'h09, irq.vec)
    @(posedge aclk);
    src[40] <= 1'b1;
    wt(6);
    `CHK("high", 7'h30, irq.vec)
    @(posedge aclk);
    src[1] <= 1'b0;
    src[3] <= 1'b0;
    src[40] <= 1'b0;
    wt(6);
    `CHK("held", 7'h30, irq.vec)
    axr(OFS_FLAG0 + 8'h04);
    `CHK("flag", 32'h100, d)
    axr(OFS_PRIO0);
    `CHK("prio", 32'h5050, d)
    axw(OFS_FLAG0 + 8'h04, 32'h100);
    wt(2);
    `CHK("next", 7'h09, irq.vec)
    axw(OFS_FLAG0, 32'hA);
    wt(2);
    `CHK("clr", 1'b0, irq.req)
    @(posedge aclk);
    ipl <= 4'h7;
    trap <= 8'h04;
    @(posedge aclk);
    trap <= 8'h00;
    wt(2);
    `CHK("trap", 12'h828, irq)
    take_chk(24'h000008);
    axw(OFS_TRAP, 32'h4);
    axw(OFS_CTRL2, 32'h8000);
    `CHK("bresp_ok", RESP_OKAY, resp)
    axr(OFS_CTRL2);
    `CHK("alt", 32'h8000, d)
    trap <= 8'h03;
    @(posedge aclk);
    trap <= 8'h00;
    wt(2);
    `CHK("trap1", 12'h818, irq)
    take_chk(24'h000106);
    axr(OFS_WINNER);
    `CHK("winner", 32'h0003_0801, d)
    axw(OFS_TRAP, 32'h3);
    ret <= 1'b1;
    @(posedge aclk);
    ret <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      @(negedge aclk);
    end while (!rdone && n < 10);
    `CHK("ret", RET_CYCLES, n)
    @(posedge aclk);
    trap <= 8'h20;
    @(posedge aclk);
    trap <= 8'h00;
    aresetn <= 1'b0;
    wt(3);
    `CHK("mid_irq", 12'h000, irq)
    `CHK("mid_isr", 25'h0, isr)
    @(posedge aclk);
    aresetn <= 1'b1;
    wt(3);
    `CHK("after", 1'b0, irq.req)
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
